// ==== verilog/twe_write_port.sv ====
// Two-wire EEPROM target, write path, with page latch and array
//
// Operation
// RULE1 - SDA is changed only while SCL is low; changes with SCL high are conditions
// RULE2 - Data is captured on SCL rising, driven after SCL falling
// RULE3 - SDA is only pulled low or released, never driven high
// RULE4 - SDA falling while SCL high is a START
// RULE5 - Master opens each command with START; bits without START are ignored
// RULE6 - SDA rising while SCL high is a STOP, ending the command
// RULE7 - STOP during a read returns the device to idle
// RULE8 - After power-up the device is idle
// RULE9 - Each accepted byte is acknowledged low on the ninth pulse
// RULE10 - Device address upper nibble must be 1010
// RULE11 - Next three bits must match chip select pins, else no ack
// RULE12 - Floating chip select pins count as logic low
// RULE13 - Eighth address bit one means read, zero means write
// RULE14 - 256 bytes in 16 pages, one 8-bit word address
// RULE15 - Byte write acks at pulses 9, 18, 27, then master STOPs
// RULE16 - STOP after write starts at most 5 ms programming, inputs ignored
// RULE17 - Page write: more data bytes each acked, STOP after any ack
// RULE18 - Only the low four address bits advance after each data byte
// RULE19 - Beyond 16 bytes the column wraps and overwrites earlier data
// RULE20 - No device address ack while programming; normal ack afterwards
// RULE21 - Word address loads the internal counter used for data bytes
`timescale 1ns/1ps

module twe_write_port #(
    parameter int P_PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl_clk,
    input  wire logic       i_sda_in,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    input  wire logic [2:0] i_chip_select_pins,
    input  wire logic [7:0] i_rd_addr,
    output logic [7:0]      o_rd_data,
    output logic            o_prog_busy
);

    // Last timer value; the range check below keeps this cut lossless
    localparam int                          PROG_LAST  = P_PROG_CYCLES - 1;
    localparam logic [twe_pkg::TIMER_W-1:0] TIMER_LAST = PROG_LAST[twe_pkg::TIMER_W-1:0];

    // Refuse a programming time the timer cannot count
    generate
        if (P_PROG_CYCLES < 1 || P_PROG_CYCLES >= (1 << twe_pkg::TIMER_W)) begin : g_bad_prog
            $error("P_PROG_CYCLES out of range");
        end
    endgenerate

    // Link side state, clocked on SCL falling
    typedef struct packed {
        twe_pkg::twe_state_type state;
        logic [3:0]             cnt;
        logic [7:0]             shift;
        logic                   oe;
        logic [7:0]             addr;
        logic [15:0][7:0]       latch;
        logic [15:0]            mask;
        logic                   wr_id;
        logic                   data_seen;
        logic                   start_seen;
        logic                   stop_seen;
        logic                   busy_m;
        logic                   busy_s;
        logic [2:0]             cs_m;
        logic [2:0]             cs_s;
    } twe_link_type;

    // System side state
    typedef struct packed {
        logic                        stop_m;
        logic                        stop_s;
        logic                        stop_d;
        logic                        id_m;
        logic                        id_s;
        logic                        done_id;
        logic                        busy;
        logic [twe_pkg::TIMER_W-1:0] timer;
        logic [7:0]                  rd_data;
        logic                        sda_val;
    } twe_sys_type;

    // There is no reset pin on the link side: power-up values give the idle state
    twe_link_type l_reg  = '0;
    twe_link_type l_next;
    twe_sys_type  s_reg;
    twe_sys_type  s_next;
    logic         start_tgl_reg = 1'b0;
    logic         stop_tgl_reg  = 1'b0;
    logic         rx_bit_reg    = 1'b1;
    logic [7:0]   byte_in;
    logic         no_start;
    logic         dev_match;
    logic         stop_ev;
    logic         prog_go;
    logic [7:0]   mem [twe_pkg::MEM_BYTES];

    // RULE4 start detect
    // A falling SDA with SCL high flips the start toggle
    always_ff @(negedge i_sda_in) begin
        if (i_scl_clk) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    // RULE6 stop detect
    // A rising SDA with SCL high flips the stop toggle; SCL may then stand still
    always_ff @(posedge i_sda_in) begin
        if (i_scl_clk) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    // RULE2 capture on rise
    // Data bit is held stable by the master across the high phase
    always_ff @(posedge i_scl_clk) begin
        rx_bit_reg <= i_sda_in;
    end

    // Byte as it stands once the current bit is shifted in
    assign byte_in  = {l_reg.shift[6:0], rx_bit_reg};
    // Start toggle is quiet for a whole setup time before SCL falls
    assign no_start = (start_tgl_reg == l_reg.start_seen);
    // RULE10 type nibble
    // RULE11 select bits
    // RULE20 busy refuses
    assign dev_match = (byte_in[7:4] == twe_pkg::DEV_TYPE)
                     && (byte_in[3:1] == l_reg.cs_s) && !l_reg.busy_s;

    // Link next state
    always_comb begin
        l_next        = l_reg;
        l_next.busy_m = s_reg.busy;
        l_next.busy_s = l_reg.busy_m;
        // RULE12 floating low
        // Strap pins carry pad pull-downs, so an open pin arrives as zero
        l_next.cs_m   = i_chip_select_pins;
        l_next.cs_s   = l_reg.cs_m;
        if (!no_start) begin
            // RULE5 command opens
            l_next.start_seen = start_tgl_reg;
            l_next.stop_seen  = stop_tgl_reg;
            l_next.state      = twe_pkg::TWE_DEVADDR;
            l_next.cnt        = '0;
            l_next.oe         = 1'b0;
        end else if (stop_tgl_reg != l_reg.stop_seen) begin
            // RULE6 stop ends command
            // SCL stands high after STOP, so it is acted on at the next fall
            l_next.stop_seen = stop_tgl_reg;
            l_next.state     = twe_pkg::TWE_IDLE;
            l_next.cnt       = '0;
            l_next.oe        = 1'b0;
        end else if (l_reg.cnt == twe_pkg::ACK_BIT) begin
            // RULE1 change on low
            // Ack is released on the fall that ends the ninth pulse
            l_next.oe  = 1'b0;
            l_next.cnt = '0;
            // RULE7 read ends
            // Read data is not served; the device waits idle for STOP
            if (l_reg.state == twe_pkg::TWE_READ) begin
                l_next.state = twe_pkg::TWE_IDLE;
            end
        end else if (l_reg.state != twe_pkg::TWE_IDLE) begin
            l_next.shift = byte_in;
            l_next.cnt   = l_reg.cnt + twe_pkg::CNT_STEP;
            if (l_reg.cnt == twe_pkg::LAST_BIT) begin
                case (l_reg.state)
                    twe_pkg::TWE_DEVADDR: begin
                        if (dev_match) begin
                            // RULE9 ack low
                            // RULE3 pull low only
                            l_next.oe = 1'b1;
                            // RULE13 direction bit
                            if (byte_in[0]) begin
                                l_next.state = twe_pkg::TWE_READ;
                            end else begin
                                l_next.state = twe_pkg::TWE_WORDADDR;
                            end
                        end else begin
                            l_next.state = twe_pkg::TWE_IDLE;
                        end
                    end
                    twe_pkg::TWE_WORDADDR: begin
                        // RULE21 address load
                        // RULE14 8-bit address
                        l_next.addr      = byte_in;
                        l_next.mask      = '0;
                        l_next.data_seen = 1'b0;
                        l_next.oe        = 1'b1;
                        l_next.state     = twe_pkg::TWE_DATA;
                    end
                    twe_pkg::TWE_DATA: begin
                        // RULE15 data ack
                        // RULE17 page bytes
                        l_next.oe = 1'b1;
                        l_next.latch[l_reg.addr[3:0]] = byte_in;
                        l_next.mask[l_reg.addr[3:0]]  = 1'b1;
                        // RULE18 column advance
                        // RULE19 column wrap
                        l_next.addr[3:0] = l_reg.addr[3:0] + twe_pkg::COL_STEP;
                        // First byte of a write marks a new page to program
                        if (!l_reg.data_seen) begin
                            l_next.wr_id     = ~l_reg.wr_id;
                            l_next.data_seen = 1'b1;
                        end
                    end
                    default: begin
                        l_next.state = twe_pkg::TWE_IDLE;
                    end
                endcase
            end
        end
    end

    // RULE1 drive on fall
    always_ff @(negedge i_scl_clk) begin
        l_reg <= l_next;
    end

    // STOP event and a fresh write id start the programming cycle
    assign stop_ev = s_reg.stop_s ^ s_reg.stop_d;
    assign prog_go = stop_ev && !s_reg.busy && (s_reg.id_s != s_reg.done_id);

    // System next state
    always_comb begin
        s_next         = s_reg;
        s_next.stop_m  = stop_tgl_reg;
        s_next.stop_s  = s_reg.stop_m;
        s_next.stop_d  = s_reg.stop_s;
        s_next.id_m    = l_reg.wr_id;
        s_next.id_s    = s_reg.id_m;
        s_next.rd_data = mem[i_rd_addr];
        s_next.sda_val = 1'b0;
        if (!i_rst_n) begin
            // RULE8 idle at power-up
            // Old toggles are absorbed so reset never triggers a write
            s_next.done_id = s_reg.id_s;
            s_next.busy    = 1'b0;
            s_next.timer   = '0;
            s_next.rd_data = '0;
        end else if (s_reg.busy) begin
            // RULE16 timed programming
            if (s_reg.timer == TIMER_LAST) begin
                s_next.busy = 1'b0;
            end else begin
                s_next.timer = s_reg.timer + twe_pkg::TIMER_STEP;
            end
        end else if (prog_go) begin
            s_next.busy    = 1'b1;
            s_next.timer   = '0;
            s_next.done_id = s_reg.id_s;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        s_reg <= s_next;
    end

    // RULE16 program page
    // Latch and mask stay still after STOP, since SCL is idle until next START
    always_ff @(posedge i_clk_sys) begin
        if (prog_go && i_rst_n) begin
            for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
                if (l_reg.mask[i]) begin
                    mem[{l_reg.addr[7:4], 4'(i)}] <= l_reg.latch[i];
                end
            end
        end
    end

    // Outputs straight from flops
    assign o_sda_oe    = l_reg.oe;
    assign o_sda_out   = s_reg.sda_val;
    assign o_rd_data   = s_reg.rd_data;
    assign o_prog_busy = s_reg.busy;

    // RULE9 ack timing check
    a_ack_timing: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE9
        $rose(l_reg.oe) |-> l_reg.cnt == twe_pkg::ACK_BIT)
        else $error("ack not placed on ninth pulse");

    // RULE1 ack one pulse
    a_ack_single: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE1
        l_reg.oe |=> !l_reg.oe)
        else $error("ack held past one pulse");

    // RULE10 wrong type refused
    a_type_refuse: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE10
        (l_reg.state == twe_pkg::TWE_DEVADDR && l_reg.cnt == twe_pkg::LAST_BIT
         && byte_in[7:4] != twe_pkg::DEV_TYPE) |=> !l_reg.oe && l_reg.state == twe_pkg::TWE_IDLE)
        else $error("foreign device type acknowledged");

    // RULE11 match acknowledged
    a_select_ack: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE11
        (no_start && l_reg.state == twe_pkg::TWE_DEVADDR && l_reg.cnt == twe_pkg::LAST_BIT
         && byte_in[7:1] == {twe_pkg::DEV_TYPE, l_reg.cs_s} && !l_reg.busy_s) |=> l_reg.oe)
        else $error("matching address not acknowledged");

    // RULE20 busy no ack
    a_busy_nack: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE20
        (no_start && l_reg.state == twe_pkg::TWE_DEVADDR
         && l_reg.cnt == twe_pkg::LAST_BIT && l_reg.busy_s) |=> !l_reg.oe)
        else $error("address acknowledged while programming");

    // RULE13 read direction
    a_read_dir: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE13
        (no_start && l_reg.state == twe_pkg::TWE_DEVADDR && l_reg.cnt == twe_pkg::LAST_BIT
         && dev_match && byte_in[0]) |=> l_reg.state == twe_pkg::TWE_READ ##1 l_reg.state == twe_pkg::TWE_IDLE)
        else $error("read direction not honoured");

    // RULE18 column only
    a_col_wrap: assert property (@(negedge i_scl_clk) disable iff (!i_rst_n) // RULE18
        (no_start && l_reg.state == twe_pkg::TWE_DATA && l_reg.cnt == twe_pkg::LAST_BIT)
        |=> l_reg.addr[7:4] == $past(l_reg.addr[7:4])
            && l_reg.addr[3:0] == $past(l_reg.addr[3:0]) + twe_pkg::COL_STEP)
        else $error("word address left its page");

    // RULE16 cycle starts
    a_prog_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE16
        prog_go |=> s_reg.busy && s_reg.timer == '0)
        else $error("programming did not start on stop");

    // RULE16 cycle ends
    a_prog_end: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE16
        (s_reg.busy && s_reg.timer == TIMER_LAST) |=> !s_reg.busy ##1 !s_reg.busy)
        else $error("programming overran its time");

    // RULE3 never high
    a_drive_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE3
        o_sda_oe |-> o_sda_out == 1'b0)
        else $error("data line driven high");

    // RULE8 idle after reset
    a_idle_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE8
        $rose(i_rst_n) |-> !s_reg.busy)
        else $error("not idle after reset");

    // Main scenarios
    c_prog_cycle: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) prog_go);
    c_poll_nack: cover property (@(negedge i_scl_clk) disable iff (!i_rst_n)
        l_reg.state == twe_pkg::TWE_DEVADDR && l_reg.cnt == twe_pkg::LAST_BIT && l_reg.busy_s);
    c_page_wrap: cover property (@(negedge i_scl_clk) disable iff (!i_rst_n)
        l_reg.state == twe_pkg::TWE_DATA && l_reg.cnt == twe_pkg::LAST_BIT && l_reg.addr[3:0] == 4'hf);
    c_read_cmd: cover property (@(negedge i_scl_clk) disable iff (!i_rst_n)
        l_reg.state == twe_pkg::TWE_READ);

endmodule

// ==== verilog/twe_pkg.sv ====
// Shared constants and types of the two-wire EEPROM write port
package twe_pkg;
    localparam logic [3:0] DEV_TYPE     = 4'ha;
    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam logic [3:0] ACK_BIT      = 4'h8;
    localparam logic [3:0] CNT_STEP     = 4'h1;
    localparam logic [3:0] COL_STEP     = 4'h1;
    localparam int         PAGE_BYTES   = 16;
    localparam int         MEM_BYTES    = 256;
    localparam int         PROG_TIME_MS = 5;
    localparam int         SYS_CLK_HZ   = 10_000_000;
    localparam int         PROG_CYCLES  = PROG_TIME_MS * (SYS_CLK_HZ / 1000);
    localparam int         TIMER_W      = 16;
    localparam logic [15:0] TIMER_STEP  = 16'h0001;

    typedef enum logic [2:0] {
        TWE_IDLE     = 3'b000,
        TWE_DEVADDR  = 3'b001,
        TWE_WORDADDR = 3'b010,
        TWE_DATA     = 3'b011,
        TWE_READ     = 3'b100
    } twe_state_type;
endpackage

// ==== testbench/twe_host_model.sv ====
// Bus master model that drives the serial clock and the data line
`timescale 1ns/1ps

module twe_host_model (
    output logic      o_scl,
    output logic      o_sda_drv,
    input  wire logic i_sda
);
    // Clock stands high between frames; the data line is released to the pull-up
    initial begin
        o_scl     = 1'b1;
        o_sda_drv = 1'b1;
    end

    task automatic start_cond();
        o_sda_drv = 1'b1;
        #15 o_scl = 1'b1;
        #15 o_sda_drv = 1'b0;
        #15 o_scl = 1'b0;
    endtask

    // data moves only while clock low
    task automatic put_bit(input logic b, output logic seen);
        o_scl = 1'b0;
        #2 o_sda_drv = b;
        #13 o_scl = 1'b1;
        seen = i_sda;
        #15 o_scl = 1'b0;
    endtask

    // Eight bits MSB first, then a released ninth bit; ack is a low wire
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic stop_cond();
        o_scl = 1'b0;
        #2 o_sda_drv = 1'b0;
        #13 o_scl = 1'b1;
        #15 o_sda_drv = 1'b1;
    endtask
endmodule

// ==== testbench/two_wire_eeprom_write_port_tb_top.sv ====
// Self-checking bench of the two-wire EEPROM write port
`timescale 1ns/1ps

module two_wire_eeprom_write_port_tb_top;
    localparam int PROG = 40;
    logic       i_clk_sys;
    logic       i_rst_n;
    logic       scl;
    logic       host_sda;
    logic       sda_out;
    logic       sda_oe;
    logic       sda;
    logic [2:0] cs;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       busy;
    int         errors;
    int         comparisons;
    int         cycles;

    // Open-drain wire with pull-up: any low driver wins
    assign sda = (sda_oe ? sda_out : 1'b1) & host_sda;

    initial i_clk_sys = 1'b0;
    always #50 i_clk_sys = ~i_clk_sys;

    twe_host_model host_u (.o_scl(scl), .o_sda_drv(host_sda), .i_sda(sda));

    twe_write_port #(.P_PROG_CYCLES(PROG)) dut_u (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl_clk(scl), .i_sda_in(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_pins(cs),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_prog_busy(busy));

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic compare_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Backdoor read: address after an edge, data valid one edge later
    task automatic check_mem(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        #1 rd_addr = a;
        @(posedge i_clk_sys);
        #1 compare_byte(rd_data, exp);
    endtask

    // Watch for busy over the STOP-to-START gap, then let programming finish
    task automatic wait_prog(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge i_clk_sys);
            #1 seen = seen | busy;
        end
        compare_bit(seen, exp);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
            @(posedge i_clk_sys);
            #1;
        end
        compare_bit(busy, 1'b0);
    endtask

    // Data bytes run first, first + 1, ... for n bytes
    task automatic write_cmd(input logic [7:0] waddr, input logic [7:0] first, input int n);
        logic ack;
        host_u.start_cond();
        host_u.send_byte({4'ha, cs, 1'b0}, ack);
        compare_bit(ack, 1'b1);
        host_u.send_byte(waddr, ack);
        compare_bit(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            host_u.send_byte(first + 8'(i), ack);
            compare_bit(ack, 1'b1);
        end
        host_u.stop_cond();
    endtask

    task automatic t_reset();
        compare_bit(busy, 1'b0);
        compare_bit(sda_oe, 1'b0);
    endtask

    task automatic t_byte_write();
        write_cmd(8'h50, 8'ha5, 1);
        wait_prog(1'b1);
        check_mem(8'h50, 8'ha5);
    endtask

    // Poll while programming, then again once it is done
    task automatic t_poll();
        logic ack;
        write_cmd(8'h10, 8'h3c, 1);
        #1100 host_u.start_cond();
        host_u.send_byte({4'ha, cs, 1'b0}, ack);
        compare_bit(ack, 1'b0);
        host_u.stop_cond();
        wait_prog(1'b1);
        host_u.start_cond();
        host_u.send_byte({4'ha, cs, 1'b0}, ack);
        compare_bit(ack, 1'b1);
        host_u.stop_cond();
        wait_prog(1'b0);
        check_mem(8'h10, 8'h3c);
    endtask

    // Eighteen bytes from column e: the last two wrap onto e and f
    task automatic t_page_wrap();
        write_cmd(8'h4e, 8'h80, 18);
        wait_prog(1'b1);
        check_mem(8'h4e, 8'h90);
        check_mem(8'h4f, 8'h91);
        check_mem(8'h40, 8'h82);
        check_mem(8'h4d, 8'h8f);
        check_mem(8'h50, 8'ha5);
    endtask

    task automatic t_refuse();
        logic       ack;
        logic [7:0] bad[2];
        bad = '{{4'hb, cs, 1'b0}, {4'ha, ~cs, 1'b0}};
        foreach (bad[i]) begin
            host_u.start_cond();
            host_u.send_byte(bad[i], ack);
            compare_bit(ack, 1'b0);
            host_u.stop_cond();
            wait_prog(1'b0);
        end
    endtask

    // After a write's STOP, bits with no START before them are ignored
    task automatic t_no_start();
        logic ack;
        write_cmd(8'h20, 8'h11, 1);
        wait_prog(1'b1);
        host_u.send_byte({4'ha, cs, 1'b0}, ack);
        compare_bit(ack, 1'b0);
        host_u.stop_cond();
        wait_prog(1'b0);
        check_mem(8'h20, 8'h11);
    endtask

    // Strap pins low as if unconnected; read direction is acked then idle
    task automatic t_read();
        logic ack;
        @(posedge i_clk_sys);
        #1 cs = 3'h0;
        #1100 host_u.start_cond();
        host_u.send_byte(8'ha1, ack);
        compare_bit(ack, 1'b1);
        host_u.send_byte(8'h00, ack);
        compare_bit(ack, 1'b0);
        host_u.stop_cond();
        wait_prog(1'b0);
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
        i_rst_n     = 1'b0;
        cs          = 3'h5;
        rd_addr     = 8'h00;
        repeat (10) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b1;
        @(posedge i_clk_sys);
        #1 t_reset();
        t_byte_write();
        t_poll();
        t_page_wrap();
        t_refuse();
        t_no_start();
        t_read();
        tally_and_finish();
    end
endmodule
